//--- rtl/mie_core.sv
/*
 * Instruction execution unit of a small 8-bit controller: accumulator,
 * flag register, program counter, call stack and shadow buffers.
 * Assumes an instruction cycle enable from the clock divider, one decoded
 * instruction per accepted cycle, and register/RAM read data available
 * combinationally for the presented address.
 */
`timescale 1ns/100ps
module mie_core
    import mie_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   cyc_en_i,
    input  wire mie_pkg::mie_instr_t    instr_i,
    input  wire logic                   instr_valid_i,
    input  wire logic [1:0]             rom_page_bits_i,
    input  wire logic [7:0]             mem_rdata_i,
    input  wire logic                   timeout_status_bit_i,
    input  wire logic                   power_down_status_bit_i,
    output logic                        instr_ready_o,
    output logic      [7:0]             mem_raddr_o,
    output mie_pkg::mie_wr_t            mem_wr_o,
    output logic      [15:0]            pc_o,
    output logic      [7:0]             acc_o,
    output logic      [7:0]             program_flag_register_o,
    output logic                        gie_set_o
);
    import mie_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic is_bank0(input mie_op_t op);
        return op inside {OP_BANK0_ADD_TO_MEM, OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET,
                          OP_BANK0_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_SET};
    endfunction

    function automatic logic writes_mem(input mie_op_t op);
        return op inside {OP_ADD_MA, OP_ADC_MA, OP_BANK0_ADD_TO_MEM, OP_SUB_MA,
                          OP_SUBTRACT_WITH_BORROW_MA, OP_AND_MA, OP_OR_MA, OP_XOR_MA,
                          OP_NIBBLE_SWAP_IN_MEM, OP_ROTATE_RIGHT_IN_MEM,
                          OP_ROTATE_LEFT_IN_MEM, OP_BIT_CLEAR, OP_BIT_SET,
                          OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET, OP_CLR,
                          OP_INCREMENT_SKIP_IN_MEM, OP_DECREMENT_SKIP_IN_MEM};
    endfunction

    function automatic logic writes_acc(input mie_op_t op);
        return op inside {OP_ADD_AM, OP_ADC_AM, OP_ADD_AI, OP_SUB_AM, OP_SUB_AI,
                          OP_SUBTRACT_WITH_BORROW_AM, OP_AND_AM, OP_AND_AI, OP_OR_AM,
                          OP_OR_AI, OP_XOR_AM, OP_XOR_AI, OP_SWAP, OP_RRC, OP_RLC,
                          OP_INCREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_TO_ACC};
    endfunction

    function automatic logic uses_imm(input mie_op_t op);
        return op inside {OP_ADD_AI, OP_SUB_AI, OP_AND_AI, OP_OR_AI, OP_XOR_AI,
                          OP_COMPARE_AND_SKIP_AI};
    endfunction

    typedef enum {ST_EXEC, ST_WAIT} mie_state_t;

    logic [7:0]  acc_q, acc_d;
    logic [7:0]  flag_q, flag_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  acc_shadow_q;
    logic [7:0]  flag_shadow_q;
    logic [15:0] stack_q [STACK_DEPTH];
    logic [1:0]  sp_q;
    logic [1:0]  wait_q;
    logic        discard_q;
    logic        gie_q;
    mie_wr_t     wr_q;
    mie_state_t  state_q;

    wire mie_op_t    op       = instr_i.op;
    wire logic [7:0] eff_addr = is_bank0(op) ? (instr_i.addr & BANK0_MASK) : instr_i.addr;
    wire logic       is_ram   = (eff_addr < SYSREG_BASE);
    wire logic [7:0] opd      = uses_imm(op) ? instr_i.imm : mem_rdata_i;
    wire logic       take     = cyc_en_i && instr_valid_i && (state_q == ST_EXEC);

    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_dc;
    logic       alu_upd_cdc;
    logic       alu_upd_z;
    logic       alu_cond;

    mie_alu u_alu (
        .op_i      (op),
        .acc_i     (acc_q),
        .opd_i     (opd),
        .bit_i     (instr_i.bit_sel),
        .c_i       (flag_q[FLAG_C]),
        .res_o     (alu_res),
        .c_o       (alu_c),
        .dc_o      (alu_dc),
        .upd_cdc_o (alu_upd_cdc),
        .upd_z_o   (alu_upd_z),
        .cond_o    (alu_cond)
    );

    // A discarded instruction (after a true skip) executes nothing
    wire logic       exec     = take && !discard_q;
    wire logic       is_rot   = op inside {OP_RRC, OP_ROTATE_RIGHT_IN_MEM, OP_RLC,
                                           OP_ROTATE_LEFT_IN_MEM};
    wire logic       is_cmp   = op inside {OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM};
    wire logic       is_skip  = op inside {OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM,
                                           OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_IN_MEM,
                                           OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_IN_MEM,
                                           OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET,
                                           OP_BANK0_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_SET};
    wire logic       is_branch = op inside {OP_JMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT};
    wire logic       mem_pen  = writes_mem(op) && is_ram;
    wire logic [1:0] extra    = {1'b0, mem_pen} + {1'b0, is_branch};
    wire logic [1:0] sp_dec   = sp_q - 2'h1;
    wire logic [15:0] jump_pc = {rom_page_bits_i, instr_i.target};

    // ****************************************************************
    // Next state of accumulator, flags and PC
    // ****************************************************************
    always_comb begin
        acc_d  = acc_q;
        flag_d = flag_q;
        pc_d   = pc_q;
        if (take) begin
            pc_d = pc_q + 16'h0001;
        end
        if (exec) begin
            if (writes_acc(op)) begin
                acc_d = alu_res;
            end
            // Compare moves carry but leaves half carry alone
            if (alu_upd_cdc || is_rot || is_cmp) begin
                flag_d[FLAG_C] = alu_c;
            end
            if (alu_upd_cdc) begin
                flag_d[FLAG_DC] = alu_dc;
            end
            if (alu_upd_z) begin
                flag_d[FLAG_Z] = (alu_res == 8'h00);
            end
            case (op)
                OP_JMP, OP_CALL: pc_d = jump_pc;
                OP_RET, OP_RETURN_FROM_INTERRUPT: pc_d = stack_q[sp_dec];
                OP_POP: begin
                    acc_d  = acc_shadow_q;
                    flag_d = (flag_shadow_q & ~STATUS_KEEP_MASK) | (flag_q & STATUS_KEEP_MASK);
                end
                default: pc_d = pc_d;
            endcase
        end
        // Status bits follow the power/timeout logic, never the instruction stream
        flag_d[FLAG_NT0] = timeout_status_bit_i;
        flag_d[FLAG_NPD] = power_down_status_bit_i;
    end

    // ****************************************************************
    // Sequencing: stall cycles and skip discard
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q   <= ST_EXEC;
            wait_q    <= 2'h0;
            discard_q <= 1'b0;
        end else if (cyc_en_i) begin
            case (state_q)
                ST_EXEC: begin
                    if (take) begin
                        discard_q <= exec && is_skip && alu_cond;
                        if (exec && extra != 2'h0) begin
                            wait_q  <= extra - 2'h1;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wait_q == 2'h0) begin
                        state_q <= ST_EXEC;
                    end else begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                default: state_q <= ST_EXEC;
            endcase
        end
    end

    // ****************************************************************
    // Architectural registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q         <= 8'h00;
            flag_q        <= FLAG_RESET;
            pc_q          <= PC_RESET;
            acc_shadow_q  <= 8'h00;
            flag_shadow_q <= 8'h00;
            sp_q          <= 2'h0;
            gie_q         <= 1'b0;
            wr_q          <= '0;
        end else begin
            acc_q  <= acc_d;
            flag_q <= flag_d;
            pc_q   <= pc_d;
            gie_q  <= exec && (op == OP_RETURN_FROM_INTERRUPT);
            wr_q   <= '{we: exec && writes_mem(op), addr: eff_addr, data: alu_res};
            if (exec && op == OP_PUSH) begin
                acc_shadow_q  <= acc_q;
                flag_shadow_q <= flag_q & ~STATUS_KEEP_MASK;
            end
            if (exec && op == OP_CALL) begin
                sp_q <= sp_q + 2'h1;
            end else if (exec && (op == OP_RET || op == OP_RETURN_FROM_INTERRUPT)) begin
                sp_q <= sp_dec;
            end
        end
    end

    // Stack storage holds no reset so it maps onto plain registers
    always_ff @(posedge clk_i) begin
        if (exec && op == OP_CALL) begin
            stack_q[sp_q] <= pc_q + 16'h0001;
        end
    end

    logic       ready_q;
    logic [7:0] raddr_q;
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ready_q <= 1'b0;
            raddr_q <= RAM_BASE;
        end else begin
            // Mirrors the state entered at this edge, so ready never lags a take
            if (cyc_en_i) begin
                ready_q <= (state_q == ST_EXEC) ? !(exec && extra != 2'h0) : (wait_q == 2'h0);
            end
            raddr_q <= eff_addr;
        end
    end

    assign instr_ready_o           = ready_q;
    assign mem_raddr_o             = raddr_q;
    assign mem_wr_o                = wr_q;
    assign pc_o                    = pc_q;
    assign acc_o                   = acc_q;
    assign program_flag_register_o = flag_q;
    assign gie_set_o               = gie_q;
endmodule

//--- rtl/mie_pkg.sv
/*
 * Package for the instruction execution unit: operation codes, flag layout,
 * address decode constants and cycle counts.
 * Assumes the fetch logic decodes each instruction word into mie_op_t.
 */
package mie_pkg;

    // ****************************************************************
    // Operations
    // ****************************************************************
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD_AM, OP_ADD_MA, OP_ADC_AM, OP_ADC_MA, OP_ADD_AI,
        OP_BANK0_ADD_TO_MEM, OP_SUB_AM, OP_SUB_MA, OP_SUB_AI,
        OP_SUBTRACT_WITH_BORROW_AM, OP_SUBTRACT_WITH_BORROW_MA,
        OP_AND_AM, OP_AND_MA, OP_AND_AI, OP_OR_AM, OP_OR_MA, OP_OR_AI,
        OP_XOR_AM, OP_XOR_MA, OP_XOR_AI, OP_SWAP, OP_NIBBLE_SWAP_IN_MEM,
        OP_RRC, OP_ROTATE_RIGHT_IN_MEM, OP_RLC, OP_ROTATE_LEFT_IN_MEM,
        OP_CLR, OP_BIT_CLEAR, OP_BIT_SET, OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET,
        OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM,
        OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_IN_MEM,
        OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_IN_MEM,
        OP_SKIP_IF_BIT_CLEAR, OP_SKIP_IF_BIT_SET,
        OP_BANK0_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_SET,
        OP_JMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_PUSH, OP_POP
    } mie_op_t;

    // Decoded instruction presented by the fetch logic
    typedef struct packed {
        mie_op_t     op;
        logic [7:0]  addr;
        logic [7:0]  imm;
        logic [2:0]  bit_sel;
        logic [13:0] target;
    } mie_instr_t;

    // Memory write request towards register/RAM space
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } mie_wr_t;

    // ****************************************************************
    // Flag register layout and constants
    // ****************************************************************
    localparam int unsigned FLAG_C   = 0;
    localparam int unsigned FLAG_DC  = 1;
    localparam int unsigned FLAG_Z   = 2;
    localparam int unsigned FLAG_NPD = 6;
    localparam int unsigned FLAG_NT0 = 7;
    localparam logic [7:0] STATUS_KEEP_MASK = 8'hc0;
    localparam logic [7:0] FLAG_RESET       = 8'hc0;
    // Addresses below SYSREG_BASE are RAM (one-cycle write-back penalty); system registers start there
    localparam logic [7:0] RAM_BASE         = 8'h00;
    localparam logic [7:0] SYSREG_BASE      = 8'h80;
    localparam logic [7:0] BANK0_MASK       = 8'h7f;
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam int unsigned STACK_DEPTH     = 4;
    // Cycle counts in instruction cycles
    localparam logic [1:0] CYC_BASE         = 2'h1;
    localparam logic [1:0] CYC_BRANCH       = 2'h2;
endpackage

//--- rtl/mie_alu.sv
/*
 * Combinational ALU of the execution unit.
 * Assumes operands are stable for the whole instruction cycle.
 */
`timescale 1ns/100ps
module mie_alu
    import mie_pkg::*;
(
    input  wire mie_pkg::mie_op_t op_i,
    input  wire logic [7:0]       acc_i,
    input  wire logic [7:0]       opd_i,
    input  wire logic [2:0]       bit_i,
    input  wire logic             c_i,
    output logic      [7:0]       res_o,
    output logic                  c_o,
    output logic                  dc_o,
    output logic                  upd_cdc_o,
    output logic                  upd_z_o,
    output logic                  cond_o
);
    // ****************************************************************
    // Arithmetic
    // ****************************************************************
    wire logic [8:0] add_full = {1'b0, acc_i} + {1'b0, opd_i};
    wire logic [8:0] adc_full = add_full + {8'h00, c_i};
    wire logic [4:0] add_half = {1'b0, acc_i[3:0]} + {1'b0, opd_i[3:0]};
    wire logic [4:0] adc_half = add_half + {4'h0, c_i};
    wire logic [8:0] sub_full = {1'b0, acc_i} - {1'b0, opd_i};
    wire logic [8:0] sbc_full = sub_full - {8'h00, ~c_i};
    wire logic [4:0] sub_half = {1'b0, acc_i[3:0]} - {1'b0, opd_i[3:0]};
    wire logic [4:0] sbc_half = sub_half - {4'h0, ~c_i};
    wire logic [7:0] bit_mask = 8'h01 << bit_i;
    wire logic       bit_val  = |(opd_i & bit_mask);

    always_comb begin
        res_o     = opd_i;
        c_o       = c_i;
        dc_o      = 1'b0;
        upd_cdc_o = 1'b0;
        upd_z_o   = 1'b0;
        cond_o    = 1'b0;
        case (op_i)
            OP_ADD_AM, OP_ADD_MA, OP_ADD_AI, OP_BANK0_ADD_TO_MEM: begin
                res_o = add_full[7:0];
                c_o = add_full[8];
                dc_o = add_half[4];
                upd_cdc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            OP_ADC_AM, OP_ADC_MA: begin
                res_o = adc_full[7:0];
                c_o = adc_full[8];
                dc_o = adc_half[4];
                upd_cdc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            OP_SUB_AM, OP_SUB_MA, OP_SUB_AI: begin
                res_o = sub_full[7:0];
                c_o = ~sub_full[8];
                dc_o = ~sub_half[4];
                upd_cdc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            OP_SUBTRACT_WITH_BORROW_AM, OP_SUBTRACT_WITH_BORROW_MA: begin
                res_o = sbc_full[7:0];
                c_o = ~sbc_full[8];
                dc_o = ~sbc_half[4];
                upd_cdc_o = 1'b1;
                upd_z_o = 1'b1;
            end
            OP_AND_AM, OP_AND_MA, OP_AND_AI: begin
                res_o = acc_i & opd_i;
                upd_z_o = 1'b1;
            end
            OP_OR_AM, OP_OR_MA, OP_OR_AI: begin
                res_o = acc_i | opd_i;
                upd_z_o = 1'b1;
            end
            OP_XOR_AM, OP_XOR_MA, OP_XOR_AI: begin
                res_o = acc_i ^ opd_i;
                upd_z_o = 1'b1;
            end
            OP_SWAP, OP_NIBBLE_SWAP_IN_MEM: begin
                res_o = {opd_i[3:0], opd_i[7:4]};
            end
            OP_RRC, OP_ROTATE_RIGHT_IN_MEM: begin
                res_o = {c_i, opd_i[7:1]};
                c_o = opd_i[0];
            end
            OP_RLC, OP_ROTATE_LEFT_IN_MEM: begin
                res_o = {opd_i[6:0], c_i};
                c_o = opd_i[7];
            end
            OP_CLR: begin
                res_o = 8'h00;
            end
            OP_BIT_CLEAR, OP_BANK0_BIT_CLEAR: begin
                res_o = opd_i & ~bit_mask;
            end
            OP_BIT_SET, OP_BANK0_BIT_SET: begin
                res_o = opd_i | bit_mask;
            end
            OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM: begin
                res_o = sub_full[7:0];
                c_o = ~sub_full[8];
                upd_z_o = 1'b1;
                cond_o = (acc_i == opd_i);
            end
            OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_IN_MEM: begin
                res_o = opd_i + 8'h01;
                cond_o = (opd_i == 8'hff);
            end
            OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_IN_MEM: begin
                res_o = opd_i - 8'h01;
                cond_o = (opd_i == 8'h01);
            end
            OP_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_CLEAR: begin
                cond_o = ~bit_val;
            end
            OP_SKIP_IF_BIT_SET, OP_BANK0_SKIP_IF_BIT_SET: begin
                cond_o = bit_val;
            end
            default: begin
                res_o = opd_i;
            end
        endcase
    end
endmodule

//--- bench/mie_checker.sv
/* Checker bound to the ports of mie_core: jump and call targets, interrupt enable
   pulse, write-back timing and stalls.
   Assumes one clock domain whose reset is rst_n_i. */
`timescale 1ns/100ps
module mie_checker
    import mie_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                cyc_en_i,
    input wire mie_pkg::mie_instr_t instr_i,
    input wire logic                instr_valid_i,
    input wire logic [1:0]          rom_page_bits_i,
    input wire logic                instr_ready_o,
    input wire mie_pkg::mie_wr_t    mem_wr_o,
    input wire logic [15:0]         pc_o,
    input wire logic [7:0]          acc_o,
    input wire logic                gie_set_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire tk  = cyc_en_i && instr_valid_i && instr_ready_o;
    wire ram = mem_wr_o.we && mem_wr_o.addr < SYSREG_BASE;
    // ********************************
    // Assertions
    // ********************************
    // A branch discarded by a skip only advances the pc, so that is allowed too
    property p_br(mie_op_t o);
        tk && instr_i.op == o |=> pc_o == {$past(rom_page_bits_i), $past(instr_i.target)}
            || pc_o == $past(pc_o) + 16'h1;
    endproperty
    a_jump_target: assert property (p_br(OP_JMP))
        else $error("jump target wrong");
    a_call_target: assert property (p_br(OP_CALL))
        else $error("call target wrong");
    a_return_from_interrupt_gie: assert property (
        tk && instr_i.op == OP_RETURN_FROM_INTERRUPT |=> gie_set_o || pc_o == $past(pc_o) + 16'h1)
        else $error("interrupt return gave no enable pulse");
    a_ret_quiet: assert property (tk && instr_i.op == OP_RET |=> !gie_set_o)
        else $error("plain return touched interrupt enable");
    a_ram_stall: assert property (ram |-> !instr_ready_o)
        else $error("ram write-back without extra cycle");
    a_sysreg_fast: assert property (mem_wr_o.we && !ram |-> instr_ready_o)
        else $error("system register write stalled");
    a_idle_hold: assert property (!tk |=> $stable(pc_o) && $stable(acc_o))
        else $error("state moved without a taken instruction");
    a_write_cause: assert property (mem_wr_o.we |-> $past(tk))
        else $error("write pulse without an instruction");
    c_jump: cover property (tk && instr_i.op == OP_JMP);
    c_ram_write: cover property (ram);
    c_return_from_interrupt: cover property (gie_set_o);
endmodule

bind mie_core mie_checker mie_checker_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_en_i(cyc_en_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .rom_page_bits_i(rom_page_bits_i),
    .instr_ready_o(instr_ready_o), .mem_wr_o(mem_wr_o), .pc_o(pc_o), .acc_o(acc_o),
    .gie_set_o(gie_set_o));

//--- bench/tb_top.sv
/* Random instruction stream into mie_core, checked against a model.
   Assumes cyc_en_i stays high, so every clock is an instruction cycle. */
`timescale 1ns/100ps
module tb_top;
    import mie_pkg::*;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, vld = 1'b0, rdy, gie, skp = 1'b0;
    logic [1:0]  pg = 2'h0, st = 2'h0;
    logic [7:0]  rd = 8'h00, acc, flg, a = 8'h00, sa = 8'h00, ra;
    logic [2:0]  fl = 3'h0, sf = 3'h0;
    logic [15:0] pco, pc = 16'h0000;
    logic [15:0] stk[$];
    mie_instr_t  ins = '0;
    mie_wr_t     wr;
    mie_op_t     op;
    integer      num_errors = 0, check_count = 0, seed = 95;
    always #2 clk_i = ~clk_i;
    mie_core mie_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_en_i(1'b1), .instr_i(ins),
        .instr_valid_i(vld), .rom_page_bits_i(pg), .mem_rdata_i(rd),
        .timeout_status_bit_i(st[1]), .power_down_status_bit_i(st[0]),
        .instr_ready_o(rdy), .mem_raddr_o(ra), .mem_wr_o(wr), .pc_o(pco), .acc_o(acc),
        .program_flag_register_o(flg), .gie_set_o(gie));
    // ********************************
    // Checking and closing
    // ********************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_rdy(output integer n);
        n = 0;
        while (rdy !== 1'b1 && n < 9) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // ********************************
    // One instruction against the model
    // ********************************
    task automatic run(input mie_op_t op);
        logic [7:0]  m, i, x, ea, r;
        logic [15:0] tg;
        logic        wm, s, e;
        integer      t, h, ci, n;
        m = $random(seed);
        i = $random(seed);
        tg = $random(seed);
        ea = $random(seed);
        // Bias the compare, increment and decrement skips so that true skips are frequent
        if (seed[1] && op inside {[OP_COMPARE_AND_SKIP_AI:OP_DECREMENT_SKIP_IN_MEM]}) begin
            i = a;
            m = op == OP_COMPARE_AND_SKIP_AM ? a : op inside {OP_INCREMENT_SKIP_TO_ACC,
                OP_INCREMENT_SKIP_IN_MEM} ? 8'hff : 8'h01;
        end
        wait_rdy(n);
        ins = '{op, ea, i, tg[15:13], tg[13:0]};
        rd = m;
        pg = m[7:6];
        st = tg[1:0];
        vld = 1'b1;
        if (op inside {OP_BANK0_ADD_TO_MEM, OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET,
            OP_BANK0_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_SET}) ea &= BANK0_MASK;
        pc = pc + 16'h1;
        if (skp) op = OP_NOP;
        x = (op inside {OP_ADD_AI, OP_SUB_AI, OP_AND_AI, OP_OR_AI, OP_XOR_AI,
            OP_COMPARE_AND_SKIP_AI}) ? i : m;
        ci = op inside {OP_ADC_AM, OP_ADC_MA} ? fl[0] :
            op inside {OP_SUBTRACT_WITH_BORROW_AM, OP_SUBTRACT_WITH_BORROW_MA} ? !fl[0] : 0;
        r = a;
        s = 1'b0;
        case (op)
            OP_ADD_AM, OP_ADD_MA, OP_ADC_AM, OP_ADC_MA, OP_ADD_AI, OP_BANK0_ADD_TO_MEM: begin
                t = a + x + ci;
                h = a[3:0] + x[3:0] + ci;
                r = t[7:0];
                fl = {r == 8'h00, h > 15, t > 255};
            end
            OP_SUB_AM, OP_SUB_MA, OP_SUB_AI, OP_SUBTRACT_WITH_BORROW_AM,
            OP_SUBTRACT_WITH_BORROW_MA, OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM: begin
                t = a - x - ci;
                h = a[3:0] - x[3:0] - ci;
                r = t[7:0];
                fl = {r == 8'h00, op inside {[OP_COMPARE_AND_SKIP_AI:OP_COMPARE_AND_SKIP_AM]} ?
                    fl[1] : h >= 0, t >= 0};
                if (op inside {OP_COMPARE_AND_SKIP_AI, OP_COMPARE_AND_SKIP_AM}) begin
                    s = a == x;
                    r = a;
                end
            end
            OP_AND_AM, OP_AND_MA, OP_AND_AI: r = a & x;
            OP_OR_AM, OP_OR_MA, OP_OR_AI: r = a | x;
            OP_XOR_AM, OP_XOR_MA, OP_XOR_AI: r = a ^ x;
            OP_SWAP, OP_NIBBLE_SWAP_IN_MEM: r = {m[3:0], m[7:4]};
            OP_RRC, OP_ROTATE_RIGHT_IN_MEM: {r, fl[0]} = {fl[0], m};
            OP_RLC, OP_ROTATE_LEFT_IN_MEM: {fl[0], r} = {m, fl[0]};
            OP_CLR: r = 8'h00;
            OP_BIT_CLEAR, OP_BANK0_BIT_CLEAR: r = m & ~(8'h01 << tg[15:13]);
            OP_BIT_SET, OP_BANK0_BIT_SET: r = m | (8'h01 << tg[15:13]);
            OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_IN_MEM: r = m + 8'h01;
            OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_IN_MEM: r = m - 8'h01;
            OP_SKIP_IF_BIT_CLEAR, OP_BANK0_SKIP_IF_BIT_CLEAR: s = !m[tg[15:13]];
            OP_SKIP_IF_BIT_SET, OP_BANK0_SKIP_IF_BIT_SET: s = m[tg[15:13]];
            OP_JMP, OP_CALL: begin
                if (op == OP_CALL) stk.push_back(pc);
                pc = {m[7:6], tg[13:0]};
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT: pc = stk.pop_back();
            OP_PUSH: {sa, sf} = {a, fl};
            OP_POP: {r, fl} = {sa, sf};
            default: ;
        endcase
        if (op inside {[OP_AND_AM:OP_XOR_AI]}) fl[2] = r == 8'h00;
        if (op inside {[OP_INCREMENT_SKIP_TO_ACC:OP_DECREMENT_SKIP_IN_MEM]}) s = r == 8'h00;
        wm = op inside {OP_ADD_MA, OP_ADC_MA, OP_BANK0_ADD_TO_MEM, OP_SUB_MA, OP_XOR_MA,
            OP_SUBTRACT_WITH_BORROW_MA, OP_AND_MA, OP_OR_MA, OP_NIBBLE_SWAP_IN_MEM,
            OP_ROTATE_RIGHT_IN_MEM, OP_ROTATE_LEFT_IN_MEM, [OP_CLR:OP_BANK0_BIT_SET],
            OP_INCREMENT_SKIP_IN_MEM, OP_DECREMENT_SKIP_IN_MEM};
        if (!wm) a = r;
        e = wm && ea < SYSREG_BASE || op inside {[OP_JMP:OP_RETURN_FROM_INTERRUPT]};
        @(negedge clk_i);
        vld = 1'b0;
        skp = s;
        chk({acc, flg}, {a, st, 3'h0, fl});
        chk(pco, pc);
        chk({14'h0, gie, wr.we}, {14'h0, op == OP_RETURN_FROM_INTERRUPT, wm});
        if (wm) chk({wr.addr, wr.data}, {ea, r});
        chk({8'h00, ra}, {8'h00, ea});
        wait_rdy(n);
        chk(n[15:0], {15'h0, e});
        // Idle edge so valid never falls and rises in one time step
        @(negedge clk_i);
    endtask
    // ********************************
    // Main sequence and watchdog
    // ********************************
    initial begin
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        repeat (800) begin
            op = mie_op_t'($unsigned($random(seed)) % (OP_POP + 1));
            if (op inside {OP_RET, OP_RETURN_FROM_INTERRUPT} && stk.size() == 0) op = OP_CALL;
            if (op == OP_CALL && stk.size() == STACK_DEPTH) op = OP_RETURN_FROM_INTERRUPT;
            run(op);
        end
        tally_and_finish;
    end
    initial begin
        #40000;
        num_errors++;
        tally_and_finish;
    end
endmodule
